// File: tb/cpu_core.sv
// CPU core stand-in issuing stores, halts and interrupt requests.
module cpu_core (
  // Clock
  input wire logic clk,
  // Store and event outputs
  output logic store_valid,
  output logic [3:0] store_addr,
  output logic [1:0] store_op,
  output logic [2:0] store_bit,
  output logic [7:0] store_data,
  output logic halt_instr,
  output logic nmi_req,
  output logic maskable_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {store_valid, store_addr, store_op, store_bit, store_data,
    halt_instr, nmi_req, maskable_irq} = 21'h000000;

  // Valid stays high across back-to-back stores; nop lowers it
  task automatic st(input logic [3:0] a, input logic [1:0] o,
    input logic [2:0] b, input logic [7:0] d);
    store_valid = 1'b1;
    {store_addr, store_op, store_bit, store_data} = {a, o, b, d};
    @(posedge clk);
    #1;
  endtask : st

  task automatic nop(input int n);
    store_valid = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
    end
  endtask : nop

  // Bit 2 halt, bit 1 NMI, bit 0 maskable request
  task automatic pulse(input logic [2:0] k);
    {halt_instr, nmi_req, maskable_irq} = k;
    @(posedge clk);
    #1;
    {halt_instr, nmi_req, maskable_irq} = 3'h0;
  endtask : pulse

  // Same data to command and control, bits 7 and 6 kept 0; no DMA here
  task automatic unlock(input logic [7:0] p, input logic [7:0] c);
    st(power_save_pkg::IDX_MODE_SELECT, power_save_pkg::OP_BYTE, 3'h0,
      p);
    st(power_save_pkg::IDX_COMMAND, power_save_pkg::OP_BYTE, 3'h0,
      c);
    st(power_save_pkg::IDX_CONTROL, power_save_pkg::OP_BYTE, 3'h0,
      c);
    nop(5);
  endtask : unlock
endmodule : cpu_core

// File: tb/power_save_pll_lock_control_assertions.sv
// Concurrent checks on the power-save controller ports.
module power_save_checker #(
  parameter int TBC_CYCLES = 4,
  parameter int LOCK_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // CPU side
  input wire logic store_valid,
  input wire logic [3:0] store_addr,
  input wire logic [1:0] store_op,
  input wire logic [2:0] store_bit,
  input wire logic [7:0] store_data,
  input wire logic [3:0] read_addr,
  input wire logic [7:0] read_data,
  input wire logic halt_instr,
  input wire logic nmi_req,
  input wire logic maskable_irq,
  input wire logic int_ack_block,
  // Clock generator side
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_en,
  input wire logic pll_en,
  input wire logic pll_unlocked,
  input wire logic standby_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Fixed counts assume the bench's TBC_CYCLES of 4 and LOCK_CYCLES of 8
  a_halt_cpu_only: assert property (
    halt_instr && cpu_clk_en |-> ##[1:2]
    (!cpu_clk_en && periph_clk_en && osc_en)) else $error("halt gating");
  a_osc_pll_pair: assert property (osc_en == pll_en)
    else $error("osc and pll enables differ");
  a_stop_sets_flag: assert property (
    $fell(osc_en) |-> pll_unlocked) else $error("flag not set at stop");
  // CPU clock returns one edge after the time base count reaches zero
  a_tbc_wait: assert property ($rose(osc_en) |->
    !cpu_clk_en [*5] ##1 cpu_clk_en) else $error("time base wait");
  a_lockup_clear: assert property ($rose(osc_en) |->
    pll_unlocked [*4] ##[1:8] !pll_unlocked) else $error("lockup flag");
  a_reset_values: assert property (
    disable iff (1'b0) rst |=>
    cpu_clk_en && osc_en && !standby_active && !pll_unlocked)
    else $error("reset values");
  a_cmd_arms: assert property (
    store_valid && store_op == 2'h0 && store_addr == 4'h2
    |=> int_ack_block) else $error("not armed");
  a_ctrl_unarmed: assert property (
    store_valid && store_addr == 4'h3 && !int_ack_block
    && !standby_active && !halt_instr |=> !standby_active [*2])
    else $error("unarmed control took effect");
  a_cpu_gate: assert property (cpu_clk_en != standby_active)
    else $error("cpu clock in standby");
endmodule : power_save_checker

bind power_save_pll_lock_control power_save_checker #(
  .TBC_CYCLES(TBC_CYCLES),
  .LOCK_CYCLES(LOCK_CYCLES)
) i_power_save_checker (
  .clk(clk),
  .rst(rst),
  .store_valid(store_valid),
  .store_addr(store_addr),
  .store_op(store_op),
  .store_bit(store_bit),
  .store_data(store_data),
  .read_addr(read_addr),
  .read_data(read_data),
  .halt_instr(halt_instr),
  .nmi_req(nmi_req),
  .maskable_irq(maskable_irq),
  .int_ack_block(int_ack_block),
  .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en),
  .osc_en(osc_en),
  .pll_en(pll_en),
  .pll_unlocked(pll_unlocked),
  .standby_active(standby_active)
);

// File: tb/power_save_pll_lock_control_bench.sv
// Self-checking bench for the power-save controller.
module power_save_pll_lock_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TBC = 4;
  localparam int LCK = 8;
  typedef struct packed {
    logic [3:0] a;
    logic [1:0] o;
    logic [2:0] b;
    logic [7:0] d;
    logic [7:0] q;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] read_addr = 4'h0;
  logic store_valid, halt_instr, nmi_req, maskable_irq, int_ack_block;
  logic [3:0] store_addr;
  logic [1:0] store_op;
  logic [2:0] store_bit;
  logic [7:0] store_data, read_data;
  logic cpu_clk_en, periph_clk_en, osc_en, pll_en, pll_unlocked;
  logic standby_active;
  logic [7:0] fl;
  int errors = 0;
  int cmp_count = 0;
  int n;
  // Store, read back at the same index
  row_t rows [11] = '{'{4'h3, 2'h0, 3'h0, 8'h02, 8'h00},
    '{4'h1, 2'h0, 3'h0, 8'hA5, 8'hA5}, '{4'h1, 2'h1, 3'h1, 8'h00, 8'hA7},
    '{4'h1, 2'h2, 3'h0, 8'h00, 8'hA6}, '{4'h1, 2'h3, 3'h7, 8'h00, 8'h26},
    '{4'h0, 2'h0, 3'h0, 8'hFF, 8'h00}, '{4'h2, 2'h0, 3'h0, 8'h5A, 8'h00},
    '{4'h1, 2'h0, 3'h0, 8'h00, 8'h00}, '{4'h3, 2'h0, 3'h0, 8'h02, 8'h00},
    '{4'h2, 2'h1, 3'h0, 8'h00, 8'h00}, '{4'h3, 2'h1, 3'h1, 8'h00, 8'h00}};

  assign fl = {1'b0, cpu_clk_en, periph_clk_en, osc_en, pll_en,
    pll_unlocked, standby_active, int_ack_block};

  cpu_core i_cpu_core (
    .clk(clk),
    .store_valid(store_valid),
    .store_addr(store_addr),
    .store_op(store_op),
    .store_bit(store_bit),
    .store_data(store_data),
    .halt_instr(halt_instr),
    .nmi_req(nmi_req),
    .maskable_irq(maskable_irq)
  );
  power_save_pll_lock_control #(
    .TBC_CYCLES(TBC),
    .LOCK_CYCLES(LCK)
  ) i_power_save_pll_lock_control (
    .clk(clk),
    .rst(rst),
    .store_valid(store_valid),
    .store_addr(store_addr),
    .store_op(store_op),
    .store_bit(store_bit),
    .store_data(store_data),
    .read_addr(read_addr),
    .read_data(read_data),
    .halt_instr(halt_instr),
    .nmi_req(nmi_req),
    .maskable_irq(maskable_irq),
    .int_ack_block(int_ack_block),
    .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en),
    .osc_en(osc_en),
    .pll_en(pll_en),
    .pll_unlocked(pll_unlocked),
    .standby_active(standby_active)
  );

  always #12.5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    read_addr = a;
    @(posedge clk);
    #1;
    chk(read_data, exp);
  endtask : rd

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  initial
  begin
    #50000;
    errors++;
    test_done();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk(fl, 8'h78);
    foreach (rows[i])
    begin
      read_addr = rows[i].a;
      i_cpu_core.st(rows[i].a, rows[i].o, rows[i].b, rows[i].d);
      i_cpu_core.nop(1);
      chk(read_data, rows[i].q);
    end
    chk(fl, 8'h78);
    // A command store arms the unlock and blocks interrupt acknowledge
    i_cpu_core.st(power_save_pkg::IDX_COMMAND, power_save_pkg::OP_BYTE, 3'h0,
      8'h00);
    chk(fl, 8'h79);
    // Idle, woken by NMI with no wait
    i_cpu_core.unlock(8'h00, 8'h02);
    chk(fl, 8'h1A);
    i_cpu_core.pulse(3'h2);
    step();
    chk(fl, 8'h78);
    rd(4'h3, 8'h00);
    // Idle entered with a wake mask: only reset leaves it
    i_cpu_core.unlock(8'h00, 8'h10);
    i_cpu_core.unlock(8'h00, 8'h12);
    i_cpu_core.pulse(3'h1);
    i_cpu_core.nop(1);
    i_cpu_core.pulse(3'h2);
    chk(fl, 8'h1A);
    rst = 1'b1;
    step();
    rst = 1'b0;
    chk(fl, 8'h78);
    rd(4'h3, 8'h00);
    // Software stop, woken by a maskable request
    i_cpu_core.unlock(8'h01, 8'h02);
    chk(fl, 8'h06);
    rd(4'h0, 8'h01);
    i_cpu_core.pulse(3'h1);
    step();
    chk(fl, 8'h1E);
    n = 1;
    while (cpu_clk_en !== 1'b1 && n < 40)
    begin
      step();
      n++;
    end
    chk(n[7:0], 8'(TBC + 1));
    chk(fl, 8'h7C);
    i_cpu_core.nop(LCK);
    chk(fl, 8'h78);
    rd(4'h0, 8'h00);
    // Stop with NMI wake masked; maskable request still wakes
    i_cpu_core.unlock(8'h01, 8'h20);
    i_cpu_core.unlock(8'h01, 8'h22);
    i_cpu_core.pulse(3'h2);
    i_cpu_core.nop(2);
    chk(fl, 8'h06);
    i_cpu_core.pulse(3'h1);
    step();
    chk(fl, 8'h1E);
    i_cpu_core.nop(LCK + TBC);
    chk(fl, 8'h78);
    rd(4'h3, 8'h20);
    // Halt by instruction, released by a maskable request
    i_cpu_core.pulse(3'h4);
    step();
    chk(fl, 8'h3A);
    i_cpu_core.pulse(3'h1);
    step();
    chk(fl, 8'h78);
    test_done();
  end
endmodule : power_save_pll_lock_control_bench

// File: verilog/lock_timer_if.sv
// Handshake between the power-save controller and its release timers.
interface lock_timer_if;
  logic start;
  logic tbc_done;
  logic lock_done;

  modport ctrl (
    output start,
    input tbc_done,
    input lock_done
  );

  modport timer (
    input start,
    output tbc_done,
    output lock_done
  );
endinterface : lock_timer_if

// File: verilog/power_save_pkg.sv
// Constants, encodings and helpers shared by the power-save controller.
package power_save_pkg;

  // Register indices on the CPU store/read port
  localparam logic [3:0] IDX_LOCK_STATUS = 4'h0;
  localparam logic [3:0] IDX_MODE_SELECT = 4'h1;
  localparam logic [3:0] IDX_COMMAND = 4'h2;
  localparam logic [3:0] IDX_CONTROL = 4'h3;

  // Store operation codes
  localparam logic [1:0] OP_BYTE = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLR = 2'h2;
  localparam logic [1:0] OP_NOT = 2'h3;

  // Field positions
  localparam int MODE_STOP_BIT = 0;
  localparam int STANDBY_REQUEST_BIT = 1;
  localparam int MASKABLE_WAKE_MASK_BIT = 4;
  localparam int NMI_WAKE_MASK_BIT = 5;
  localparam int UNLOCKED_BIT = 0;

  // Reset values and command read value
  localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COMMAND_READ_VALUE = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEBASE_WAIT_NS = 2000;
  localparam int LOCKUP_TIME_NS = 5000;
  localparam int TIMEBASE_WAIT_CYCLES =
    (TIMEBASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCKUP_CYCLES =
    (LOCKUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'b00001,
    ST_HALT = 5'b00010,
    ST_IDLE = 5'b00100,
    ST_STOP = 5'b01000,
    ST_STOP_WAIT = 5'b10000
  } ps_state_t;

  // Byte store or single-bit set, clear, invert
  function automatic logic [7:0] apply_store(
    input logic [7:0] old,
    input logic [1:0] op,
    input logic [2:0] bit_sel,
    input logic [7:0] data
  );
    logic [7:0] r;
    r = old;
    case (op)
      OP_BYTE: r = data;
      OP_SET: r[bit_sel] = 1'b1;
      OP_CLR: r[bit_sel] = 1'b0;
      OP_NOT: r[bit_sel] = ~old[bit_sel];
      default: r = old;
    endcase
    return r;
  endfunction : apply_store

endpackage : power_save_pkg

// File: verilog/power_save_pll_lock_control.sv
// Power-save mode controller with protected control register and lock flag.

// Overview of operation
// [R1] Lock status register is read-only, byte or bit read; writes ignored.
// [R2] Unlocked flag reads 0 when locked, 1 after standby loses lock.
// [R3] Lock loss not caused by standby leaves the flag at 0.
// [R4] Lockup interval runs from power-on or stop release until lock.
// [R5] Halt stops only the CPU clock; oscillator, PLL, peripherals run.
// [R6] Halt is entered only by the halt instruction.
// [R7] Idle keeps oscillator and PLL running, gates all system clocks.
// [R8] Leaving idle returns to normal with no stabilisation wait.
// [R9] Mode select register chooses between idle and software stop.
// [R10] Software stop stops PLL output together with the oscillator.
// [R11] After stop release execution waits for the time base count.
// [R12] Direct mode: source holds oscillator input low; same wait applies.
// [R13] Mode select acts only with standby bit set; byte and bit stores.
// [R14] Command register is byte-write only; reads give undefined data.
// [R15] Control write counts only directly after a command register store.
// [R16] Stop is released by unmasked interrupts when wake masks allow.
// [R17] Setting the standby bit enters the selected standby mode.
// [R18] Software writes 0 to control bits 7 and 6.
// [R19] Software sets wake masks before, not with, the standby bit.
// [R20] Software sets mode select, writes command, then stores control.
// [R21] No interrupt acknowledge between command store and next store.
// [R22] Software runs five no-ops after entering idle or stop.
// [R23] Software finishes DMA before the protected write sequence.
// [R24] Control register reads need no unlock sequence.
// [R25] Halt released by NMI, unmasked maskable interrupt or reset.
// [R26] Idle wakes on interrupts only if both wake masks were 0.
// [R27] Unlocked flag set at stop entry, cleared when lockup expires.
module power_save_pll_lock_control #(
  parameter int TBC_CYCLES = power_save_pkg::TIMEBASE_WAIT_CYCLES,
  parameter int LOCK_CYCLES = power_save_pkg::LOCKUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // CPU store port
  input wire logic store_valid,
  input wire logic [3:0] store_addr,
  input wire logic [1:0] store_op,
  input wire logic [2:0] store_bit,
  input wire logic [7:0] store_data,
  // CPU read port
  input wire logic [3:0] read_addr,
  output logic [7:0] read_data,
  // CPU events and interrupt requests
  input wire logic halt_instr,
  input wire logic nmi_req,
  input wire logic maskable_irq,
  output logic int_ack_block,
  // Clock generator controls
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic pll_en,
  output logic pll_unlocked,
  output logic standby_active
);

  lock_timer_if tmr_if ();

  release_timer #(
    .TBC_CYCLES(TBC_CYCLES),
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_release_timer (
    .clk(clk),
    .rst(rst),
    .tmr(tmr_if.timer)
  );

  power_save_pkg::ps_state_t state;
  power_save_pkg::ps_state_t next_state;
  logic [7:0] mode_select;
  logic [7:0] next_mode_select;
  logic [7:0] control;
  logic [7:0] next_control;
  logic unlock_armed;
  logic next_unlock_armed;
  logic idle_wakeable;
  logic next_idle_wakeable;
  logic unlocked_flag;
  logic next_unlocked_flag;
  logic [7:0] next_read_data;
  logic next_cpu_clk_en;
  logic next_periph_clk_en;
  logic next_osc_en;
  logic next_pll_en;

  logic wr_mode;
  logic wr_cmd;
  logic wr_ctrl;
  logic ctrl_accept;
  logic [7:0] ctrl_written;
  logic any_wake;
  logic stop_wake;
  logic stop_release;

  assign wr_mode = store_valid
    && (store_addr == power_save_pkg::IDX_MODE_SELECT);
  assign wr_cmd = store_valid && (store_addr == power_save_pkg::IDX_COMMAND)
    && (store_op == power_save_pkg::OP_BYTE); // see [R14]
  assign wr_ctrl = store_valid
    && (store_addr == power_save_pkg::IDX_CONTROL);
  assign ctrl_accept = wr_ctrl && unlock_armed; // see [R15]
  assign ctrl_written = power_save_pkg::apply_store(control, store_op,
    store_bit, store_data);

  assign any_wake = nmi_req || maskable_irq; // see [R25]
  // Interrupt mask registers are applied upstream of maskable_irq
  assign stop_wake =
    (nmi_req && !control[power_save_pkg::NMI_WAKE_MASK_BIT])
    || (maskable_irq
    && !control[power_save_pkg::MASKABLE_WAKE_MASK_BIT]); // see [R16]
  assign stop_release = (state == power_save_pkg::ST_STOP) && stop_wake;
  assign tmr_if.start = stop_release; // see [R4]

  // Unlock sequence and register stores
  always_comb
  begin
    next_mode_select = mode_select;
    next_control = control;
    next_unlock_armed = unlock_armed;
    if (wr_mode)
      next_mode_select = power_save_pkg::apply_store(mode_select, store_op,
        store_bit, store_data); // see [R13]
    if (store_valid)
      next_unlock_armed = wr_cmd; // see [R15]
    if (ctrl_accept)
      next_control = ctrl_written;
    // Standby bit drops when idle returns to normal, or at stop release before the time base wait
    if ((state == power_save_pkg::ST_IDLE && next_state
      == power_save_pkg::ST_NORMAL) || stop_release)
      next_control[power_save_pkg::STANDBY_REQUEST_BIT] = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_select <= power_save_pkg::MODE_SELECT_RESET;
      control <= power_save_pkg::CONTROL_RESET;
      unlock_armed <= 1'b0;
    end
    else
    begin
      mode_select <= next_mode_select;
      control <= next_control;
      unlock_armed <= next_unlock_armed;
    end
  end

  // Standby state machine
  always_comb
  begin
    next_state = state;
    next_idle_wakeable = idle_wakeable;
    case (state)
      power_save_pkg::ST_NORMAL:
      begin
        if (halt_instr)
          next_state = power_save_pkg::ST_HALT; // see [R6]
        else if (ctrl_accept
          && ctrl_written[power_save_pkg::STANDBY_REQUEST_BIT]) // see [R17]
        begin
          // Mode select is sampled only here, while the standby bit sets
          if (mode_select[power_save_pkg::MODE_STOP_BIT]) // see [R9]
            next_state = power_save_pkg::ST_STOP;
          else
            next_state = power_save_pkg::ST_IDLE;
          next_idle_wakeable =
            !ctrl_written[power_save_pkg::NMI_WAKE_MASK_BIT]
            && !ctrl_written[power_save_pkg::MASKABLE_WAKE_MASK_BIT];
        end
      end
      power_save_pkg::ST_HALT:
      begin
        if (any_wake)
          next_state = power_save_pkg::ST_NORMAL; // see [R25]
      end
      power_save_pkg::ST_IDLE:
      begin
        if (idle_wakeable && any_wake)
          next_state = power_save_pkg::ST_NORMAL; // see [R26] and [R8]
      end
      power_save_pkg::ST_STOP:
      begin
        if (stop_wake)
          next_state = power_save_pkg::ST_STOP_WAIT;
      end
      power_save_pkg::ST_STOP_WAIT:
      begin
        // Also covers direct mode, where the source held the input low
        if (tmr_if.tbc_done)
          next_state = power_save_pkg::ST_NORMAL; // see [R11] and [R12]
      end
      default:
        next_state = power_save_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= power_save_pkg::ST_NORMAL;
      idle_wakeable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idle_wakeable <= next_idle_wakeable;
    end
  end

  // Lock flag: only standby can set it, so other lock losses read 0
  always_comb
  begin
    next_unlocked_flag = unlocked_flag;
    if (tmr_if.lock_done && state != power_save_pkg::ST_STOP)
      next_unlocked_flag = 1'b0; // see [R27]
    if (next_state == power_save_pkg::ST_STOP)
      next_unlocked_flag = 1'b1; // see [R2] and [R3]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      unlocked_flag <= 1'b0;
    else
      unlocked_flag <= next_unlocked_flag;
  end

  // Clock enables follow the next state so they switch with it
  always_comb
  begin
    next_cpu_clk_en = (next_state == power_save_pkg::ST_NORMAL);
    next_periph_clk_en = (next_state == power_save_pkg::ST_NORMAL)
      || (next_state == power_save_pkg::ST_HALT); // see [R5] and [R7]
    next_osc_en = (next_state != power_save_pkg::ST_STOP);
    next_pll_en = (next_state != power_save_pkg::ST_STOP); // see [R10]
  end

  // Read port: lock status and control read directly, no sequence
  always_comb
  begin
    next_read_data = 8'h00;
    case (read_addr)
      power_save_pkg::IDX_LOCK_STATUS:
        next_read_data[power_save_pkg::UNLOCKED_BIT] =
          unlocked_flag; // see [R1]
      power_save_pkg::IDX_MODE_SELECT:
        next_read_data = mode_select;
      power_save_pkg::IDX_COMMAND:
        next_read_data = power_save_pkg::COMMAND_READ_VALUE; // see [R14]
      power_save_pkg::IDX_CONTROL:
        next_read_data = control; // see [R24]
      default:
        next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      read_data <= 8'h00;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      pll_en <= 1'b1;
      pll_unlocked <= 1'b0;
      standby_active <= 1'b0;
      int_ack_block <= 1'b0;
    end
    else
    begin
      read_data <= next_read_data;
      cpu_clk_en <= next_cpu_clk_en;
      periph_clk_en <= next_periph_clk_en;
      osc_en <= next_osc_en;
      pll_en <= next_pll_en;
      pll_unlocked <= next_unlocked_flag;
      standby_active <= (next_state != power_save_pkg::ST_NORMAL);
      int_ack_block <= next_unlock_armed; // see [R21]
    end
  end

endmodule : power_save_pll_lock_control

// File: verilog/release_timer.sv
// Time base wait and PLL lockup counters, both started at stop release.
module release_timer #(
  parameter int TBC_CYCLES = power_save_pkg::TIMEBASE_WAIT_CYCLES,
  parameter int LOCK_CYCLES = power_save_pkg::LOCKUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  lock_timer_if.timer tmr
);

  localparam logic [15:0] TBC_LOAD = 16'(TBC_CYCLES);
  localparam logic [15:0] LOCK_LOAD = 16'(LOCK_CYCLES);

  logic [15:0] tbc_cnt;
  logic [15:0] lock_cnt;
  logic [15:0] next_tbc_cnt;
  logic [15:0] next_lock_cnt;

  always_comb
  begin
    next_tbc_cnt = tbc_cnt;
    next_lock_cnt = lock_cnt;
    if (tmr.start)
    begin
      next_tbc_cnt = TBC_LOAD;
      next_lock_cnt = LOCK_LOAD;
    end
    else
    begin
      if (tbc_cnt != 16'h0000)
        next_tbc_cnt = tbc_cnt - 16'h0001;
      if (lock_cnt != 16'h0000)
        next_lock_cnt = lock_cnt - 16'h0001;
    end
  end

  // Lockup is counted from reset release as well as from stop release
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tbc_cnt <= 16'h0000;
      lock_cnt <= LOCK_LOAD; // see [R4]
    end
    else
    begin
      tbc_cnt <= next_tbc_cnt;
      lock_cnt <= next_lock_cnt;
    end
  end

  assign tmr.tbc_done = (tbc_cnt == 16'h0000);
  assign tmr.lock_done = (lock_cnt == 16'h0000);

endmodule : release_timer
